// file: design/tcm_top.sv
/*
 * compare match unit: control and compare registers, pin latch,
 * special event trigger and interrupt status.
 * assumes: timer, adc and pin pad sit outside on the same mclk;
 * the pad applies its own direction bit.
 */
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_params.svh"

module tcm_top
    import tcm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [`TCM_AW-1:0] reg_addr,
    input wire tcm_pkg::tcm_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output tcm_pkg::tcm_byte_t reg_rdata,
    // timer
    input wire tcm_pkg::tcm_count_t timer_count,
    input wire logic timer_tick,
    output logic timer_clear,
    // adc
    input wire logic adc_enable,
    output logic adc_start,
    // compare pin
    output logic compare_output_pin_o,
    output logic compare_output_pin_oe,
    // events
    output logic special_event_trigger,
    output logic match_interrupt_flag,
    output logic irq
);
    import tcm_pkg::*;

    // ------------------------------------------------
    // registers
    // ------------------------------------------------
    tcm_byte_t ctrl_r;
    tcm_byte_t vlo_r;
    tcm_byte_t vhi_r;
    tcm_byte_t rdata_r;
    logic [`TCM_ST_W-1:0] stat_r;
    logic [`TCM_ST_W-1:0] ena_r;
    logic [`TCM_ST_W-1:0] stat_set;
    logic [`TCM_ST_W-1:0] stat_clr;
    logic out_r;

    tcm_mode_t mode;
    tcm_count_t cmp_value;
    logic wr_ctrl;
    logic wr_zero;
    logic equal;
    logic match_evt;
    logic special_mode;

    assign mode = ctrl_r[`TCM_MODE_MSB:0];
    assign cmp_value = {vhi_r, vlo_r};
    assign special_mode = (mode == `TCM_MODE_SPECIAL);
    assign wr_ctrl = reg_wr && (reg_addr == `TCM_OFS_CTRL);
    assign wr_zero = wr_ctrl && (reg_wdata == `TCM_BYTE_RST);

    // ------------------------------------------------
    // match detection
    // ------------------------------------------------
    tcm_match_detect u_detect (
        .mclk(mclk),
        .rst_n(rst_n),
        .timer_count(timer_count),
        .timer_tick(timer_tick),
        .compare_value(cmp_value),
        .armed(tcm_is_compare(mode)),
        .special_mode(special_mode),
        .equal(equal),
        .match_evt(match_evt),
        .timer_clear(timer_clear)
    );

    // ------------------------------------------------
    // register writes
    // ------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ctrl_r <= `TCM_BYTE_RST;
        else if (wr_ctrl)
            ctrl_r <= reg_wdata;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            vlo_r <= `TCM_BYTE_RST;
        else if (reg_wr && (reg_addr == `TCM_OFS_VLO))
            vlo_r <= reg_wdata;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            vhi_r <= `TCM_BYTE_RST;
        else if (reg_wr && (reg_addr == `TCM_OFS_VHI))
            vhi_r <= reg_wdata;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ena_r <= `TCM_ST_RST;
        else if (reg_wr && (reg_addr == `TCM_OFS_ENA))
            ena_r <= reg_wdata[`TCM_ST_W-1:0];
    end

    // ------------------------------------------------
    // compare output latch
    // ------------------------------------------------
    // a zero control write wins over a match in the same cycle
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            out_r <= 1'b0;
        else if (wr_zero)
            out_r <= 1'b0;
        else if (match_evt)
        begin
            case (mode)
                `TCM_MODE_TOGGLE: out_r <= !out_r;
                `TCM_MODE_SET: out_r <= 1'b1;
                `TCM_MODE_CLEAR: out_r <= 1'b0;
                default: out_r <= out_r;
            endcase
        end
    end

    // the pad direction bit is software's business; oe only says
    // whether the unit claims the pin
    assign compare_output_pin_o = out_r;
    assign compare_output_pin_oe = tcm_drives_pin(mode);

    // ------------------------------------------------
    // special event trigger
    // ------------------------------------------------
    // combinational so it lands in the match cycle itself
    assign special_event_trigger = match_evt && special_mode;
    assign adc_start = special_event_trigger && adc_enable;
    // timer_clear is a plain load-zero, not a wrap: the timer must not
    // raise its overflow flag for it

    // ------------------------------------------------
    // interrupt status
    // ------------------------------------------------
    assign stat_set[`TCM_ST_MATCH] = match_evt;
    assign stat_set[`TCM_ST_SPECIAL] = special_event_trigger;
    assign stat_clr = (reg_wr && (reg_addr == `TCM_OFS_CLR))
        ? reg_wdata[`TCM_ST_W-1:0] : `TCM_ST_RST;

    // set beats clear so no event is lost
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            stat_r <= `TCM_ST_RST;
        else
            stat_r <= (stat_r & ~stat_clr) | stat_set;
    end

    assign match_interrupt_flag = stat_r[`TCM_ST_MATCH];
    assign irq = |(stat_r & ena_r);

    // ------------------------------------------------
    // register reads
    // ------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rdata_r <= `TCM_BYTE_RST;
        else if (reg_rd)
        begin
            case (reg_addr)
                `TCM_OFS_CTRL: rdata_r <= ctrl_r;
                `TCM_OFS_VLO: rdata_r <= vlo_r;
                `TCM_OFS_VHI: rdata_r <= vhi_r;
                `TCM_OFS_STAT: rdata_r <= tcm_byte_t'(stat_r);
                `TCM_OFS_ENA: rdata_r <= tcm_byte_t'(ena_r);
                default: rdata_r <= `TCM_BYTE_RST;
            endcase
        end
        else
            rdata_r <= `TCM_BYTE_RST;
    end

    assign reg_rdata = rdata_r;

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_trig;
        special_event_trigger && adc_enable;
    endsequence

    sequence s_next_edge_eq;
        timer_tick && equal && special_mode;
    endsequence

    // two quiet cycles fit a timer that steps every fourth clock; a faster
    // timer only makes the reset-edge checks vacuous, never false
    sequence s_special_match;
        special_event_trigger && !wr_ctrl;
    endsequence

    sequence s_quiet_ticks;
        (!timer_tick)[*2];
    endsequence

    sequence s_edge_lost;
        timer_tick && !equal;
    endsequence

    AST_MATCH_EQUAL: assert property (
        match_evt |-> (timer_count == cmp_value) && tcm_is_compare(mode))
        else $error("match without equal count");

    AST_FLAG_SET: assert property (
        match_evt |=> stat_r[`TCM_ST_MATCH] && match_interrupt_flag)
        else $error("match did not set flag");

    AST_TOGGLE: assert property (
        match_evt && (mode == `TCM_MODE_TOGGLE) && !wr_zero
        |=> compare_output_pin_o != $past(compare_output_pin_o))
        else $error("toggle mode did not toggle");

    AST_SET_CLR: assert property (
        match_evt && tcm_drives_pin(mode) && (mode != `TCM_MODE_TOGGLE)
        && !wr_zero |=> compare_output_pin_o == $past(mode == `TCM_MODE_SET))
        else $error("set or clear mode wrong level");

    AST_ZERO_WRITE: assert property (
        wr_zero |=> !compare_output_pin_o && (ctrl_r == `TCM_BYTE_RST))
        else $error("zero control write left latch high");

    AST_NO_PIN: assert property (
        ((mode == `TCM_MODE_SWINT) || special_mode) && !wr_zero
        |-> !compare_output_pin_oe ##1 $stable(compare_output_pin_o))
        else $error("pin touched in non pin mode");

    AST_ADC: assert property (
        s_trig |-> adc_start && !timer_clear)
        else $error("trigger did not start adc");

    AST_CLEAR_AT_EDGE: assert property (
        s_special_match ##1 s_quiet_ticks ##1 s_next_edge_eq
        |-> timer_clear)
        else $error("timer not cleared at next edge");

    AST_CLEAR_NEEDS_MATCH: assert property (
        timer_clear |-> equal && $past(special_mode) && !special_event_trigger)
        else $error("timer cleared without holding match");

    AST_SINGLE_MATCH: assert property (
        match_evt && !timer_tick |=> !match_evt)
        else $error("repeated match on one count");

    AST_IRQ: assert property (
        match_evt && ena_r[`TCM_ST_MATCH] |=> irq)
        else $error("enabled match gave no irq");

    // ------------------------------------------------
    // further output checks
    // ------------------------------------------------
    AST_OE_MODES: assert property (
        compare_output_pin_oe == ((mode == `TCM_MODE_TOGGLE) || (mode == `TCM_MODE_SET)
        || (mode == `TCM_MODE_CLEAR)))
        else $error("pin claimed in wrong mode");

    AST_PIN_HOLD: assert property (
        !match_evt && !wr_zero |=> $stable(compare_output_pin_o))
        else $error("pin latch moved without match");

    AST_OFF_SILENT: assert property (
        (mode == `TCM_MODE_OFF) |-> !match_evt && !special_event_trigger && !timer_clear)
        else $error("event while compare is off");

    AST_STATUS_HOLD: assert property (
        stat_r[`TCM_ST_MATCH] && !stat_clr[`TCM_ST_MATCH] |=> match_interrupt_flag)
        else $error("match flag lost without clear");

    AST_STATUS_CLEAR: assert property (
        stat_clr[`TCM_ST_MATCH] && !match_evt |=> !match_interrupt_flag)
        else $error("match flag not cleared");

    AST_SET_WINS: assert property (
        match_evt && stat_clr[`TCM_ST_MATCH] |=> match_interrupt_flag)
        else $error("clear beat a match in the same cycle");

    AST_IRQ_QUIET: assert property (
        (stat_r == `TCM_ST_RST) |-> !irq)
        else $error("irq without status");

    AST_ZERO_BEATS_MATCH: assert property (
        wr_zero && match_evt |=> !compare_output_pin_o)
        else $error("match beat a zero control write");

    AST_SWINT_QUIET: assert property (
        (mode == `TCM_MODE_SWINT) |-> !special_event_trigger && !adc_start && !timer_clear)
        else $error("trigger in software interrupt mode");

    AST_ADC_GATED: assert property (
        adc_start |-> special_event_trigger && adc_enable && !compare_output_pin_oe)
        else $error("adc start outside a trigger");

    AST_SPECIAL_FLAG: assert property (
        special_event_trigger |=> stat_r[`TCM_ST_SPECIAL] && match_interrupt_flag)
        else $error("trigger left no status");

    AST_CLEAR_ONCE: assert property (
        timer_clear |=> !timer_clear)
        else $error("timer clear longer than one cycle");

    AST_CLEAR_CANCEL: assert property (
        s_special_match ##1 s_quiet_ticks ##1 s_edge_lost |-> !timer_clear)
        else $error("timer cleared after match was removed");
endmodule : tcm_top

`default_nettype wire

// file: design/tcm_params.svh
/*
 * constants of the compare match unit: register offsets, mode codes,
 * status bit positions and reset values.
 * assumes: included by bare name; definitions only.
 */
`ifndef TCM_PARAMS_SVH
`define TCM_PARAMS_SVH

// ------------------------------------------------
// register offsets
// ------------------------------------------------
`define TCM_AW 3
`define TCM_OFS_CTRL 3'h0
`define TCM_OFS_VLO 3'h1
`define TCM_OFS_VHI 3'h2
`define TCM_OFS_STAT 3'h3
`define TCM_OFS_CLR 3'h4
`define TCM_OFS_ENA 3'h5

// ------------------------------------------------
// mode codes of compare_mode_select
// ------------------------------------------------
`define TCM_MODE_MSB 3
`define TCM_MODE_OFF 4'h0
`define TCM_MODE_TOGGLE 4'h2
`define TCM_MODE_SET 4'h8
`define TCM_MODE_CLEAR 4'h9
`define TCM_MODE_SWINT 4'ha
`define TCM_MODE_SPECIAL 4'hb

// ------------------------------------------------
// status layout and reset values
// ------------------------------------------------
`define TCM_ST_W 2
`define TCM_ST_MATCH 0
`define TCM_ST_SPECIAL 1
`define TCM_BYTE_RST 8'h00
`define TCM_ST_RST 2'h0

`endif

// file: design/tcm_pkg.sv
/*
 * types and mode decoding of the compare match unit.
 * assumes: tcm_params.svh is on the include path.
 */
`include "tcm_params.svh"

package tcm_pkg;
    typedef logic [3:0] tcm_mode_t;
    typedef logic [7:0] tcm_byte_t;
    typedef logic [15:0] tcm_count_t;

    // modes in which the unit owns the pin
    function automatic logic tcm_drives_pin(input tcm_mode_t m);
        tcm_drives_pin = (m == `TCM_MODE_TOGGLE) || (m == `TCM_MODE_SET)
            || (m == `TCM_MODE_CLEAR);
    endfunction : tcm_drives_pin

    // any compare mode
    function automatic logic tcm_is_compare(input tcm_mode_t m);
        tcm_is_compare = tcm_drives_pin(m) || (m == `TCM_MODE_SWINT)
            || (m == `TCM_MODE_SPECIAL);
    endfunction : tcm_is_compare
endpackage : tcm_pkg

// file: design/tcm_match_detect.sv
/*
 * equality detector between the timer count and the compare value,
 * plus the pending timer reset of the special event trigger.
 * assumes: timer_tick is a one-cycle pulse in mclk, the timer takes
 * its next value at the end of that cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module tcm_match_detect
    import tcm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // timer side
    input wire tcm_pkg::tcm_count_t timer_count,
    input wire logic timer_tick,
    // configuration
    input wire tcm_pkg::tcm_count_t compare_value,
    input wire logic armed,
    input wire logic special_mode,
    // results
    output logic equal,
    output logic match_evt,
    output logic timer_clear
);
    logic tick_d_r;
    logic pend_r;

    assign equal = (timer_count == compare_value);
    // only the cycle after a count update is looked at
    assign match_evt = armed && tick_d_r && equal;
    // reset only if the match still holds at the next timer edge
    assign timer_clear = pend_r && timer_tick && equal && special_mode;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            tick_d_r <= 1'b0;
        else
            tick_d_r <= timer_tick;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pend_r <= 1'b0;
        else if (match_evt && special_mode)
            pend_r <= 1'b1;
        else if (timer_tick || !special_mode)
            pend_r <= 1'b0;
    end
endmodule : tcm_match_detect

`default_nettype wire

// file: sim/tcm_timer_model.sv
/*
 * timer partner of the compare match unit: 16-bit count, tick pulse,
 * load of zero on timer_clear, own overflow flag.
 * assumes: same mclk as the unit; one tick every 4 mclk while run is high.
 */
`timescale 1ns/100ps
`default_nettype none

module tcm_timer_model
    import tcm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic timer_clear,
    // timer side
    output tcm_pkg::tcm_count_t timer_count,
    output logic timer_tick,
    output logic overflow_flag
);
    logic [1:0] div_r;

    // ticks derived from mclk, never on every mclk
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            div_r <= 2'h0;
        else if (run)
            div_r <= div_r + 2'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            timer_tick <= 1'b0;
        else
            timer_tick <= run && (div_r == 2'h3);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            timer_count <= 16'h0000;
        else if (timer_tick)
            timer_count <= timer_clear ? 16'h0000 : timer_count + 16'h0001;
    end

    // only a real wrap raises it, a clear does not
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            overflow_flag <= 1'b0;
        else if (timer_tick && !timer_clear && timer_count == 16'hffff)
            overflow_flag <= 1'b1;
    end
endmodule : tcm_timer_model

`default_nettype wire

// file: sim/timer_compare_match_unit_tb.sv
/*
 * self-checking bench of the compare match unit.
 * assumes: tcm_pkg and tcm_params.svh compiled first, timer model beside.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tcm_params.svh"

module timer_compare_match_unit_tb;
    import tcm_pkg::*;

    logic mclk, rst_n, reg_wr, reg_rd, run, adc_enable, overflow_flag;
    logic [2:0] reg_addr;
    tcm_byte_t reg_wdata, reg_rdata, rv;
    tcm_count_t timer_count, cv;
    logic timer_tick, timer_clear, adc_start, pin_o, pin_oe, trig, flag, irq;
    int fail_count = 0;
    int samples_checked = 0;

    tcm_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_count(timer_count),
        .timer_tick(timer_tick), .timer_clear(timer_clear), .adc_enable(adc_enable),
        .adc_start(adc_start), .compare_output_pin_o(pin_o), .compare_output_pin_oe(pin_oe),
        .special_event_trigger(trig), .match_interrupt_flag(flag), .irq(irq));

    tcm_timer_model tmr (.mclk(mclk), .rst_n(rst_n), .run(run), .timer_clear(timer_clear),
        .timer_count(timer_count), .timer_tick(timer_tick), .overflow_flag(overflow_flag));

    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input tcm_byte_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [2:0] a, output tcm_byte_t d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge mclk);
    endtask : rd

    // stops the timer, programs a compare value d ticks ahead, then the mode
    task automatic arm(input tcm_mode_t m, input tcm_count_t d, input logic go);
        tcm_count_t v;
        run <= 1'b0;
        repeat (3) @(posedge mclk);
        v = timer_count + d;
        wr(`TCM_OFS_VHI, v[15:8]);
        wr(`TCM_OFS_VLO, v[7:0]);
        wr(`TCM_OFS_CLR, 8'h03);
        wr(`TCM_OFS_CTRL, {4'h0, m});
        run <= go;
    endtask : arm

    // bounded wait: 0 match flag, 1 trigger, 2 timer tick
    task automatic wait_on(input int s);
        int n;
        n = 0;
        while (n < 80 && (s == 0 ? flag : s == 1 ? trig : timer_tick) !== 1'b1)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({15'h0, (n < 80)}, 16'h1);
    endtask : wait_on

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        run = 1'b0;
        adc_enable = 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (int a = 0; a < 8; a++)
        begin
            rd(3'(a), rv);
            chk(rv, 16'h0);
        end
        wr(`TCM_OFS_ENA, 8'h01);
        // count held equal to the compare value gives no match
        arm(`TCM_MODE_TOGGLE, 16'h0, 1'b0);
        repeat (10) @(posedge mclk);
        #1;
        chk(flag, 16'h0);
        chk(pin_oe, 16'h1);
        // pad direction is taken as output from here on, so pin_o is the pin
        arm(`TCM_MODE_TOGGLE, 16'h2, 1'b1);
        wait_on(0);
        chk(pin_o, 16'h1);
        chk(irq, 16'h1);
        rd(`TCM_OFS_STAT, rv);
        chk(rv, 16'h1);
        wr(`TCM_OFS_ENA, 8'h00);
        chk(irq, 16'h0);
        chk(pin_o, 16'h1);
        wr(`TCM_OFS_ENA, 8'h01);
        arm(`TCM_MODE_CLEAR, 16'h2, 1'b1);
        wait_on(0);
        chk(pin_o, 16'h0);
        arm(`TCM_MODE_SET, 16'h3, 1'b1);
        wait_on(0);
        chk(pin_o, 16'h1);
        wr(`TCM_OFS_CTRL, 8'h00);
        chk({pin_o, pin_oe}, 16'h0);
        arm(`TCM_MODE_SWINT, 16'h2, 1'b1);
        wait_on(0);
        chk({pin_o, pin_oe, flag}, 16'h1);
        // trigger now, timer cleared at its next tick
        adc_enable <= 1'b1;
        arm(`TCM_MODE_SPECIAL, 16'h2, 1'b1);
        wait_on(1);
        chk({trig, adc_start, pin_oe}, 16'h6);
        chk(timer_clear, 16'h0);
        wait_on(2);
        chk(timer_clear, 16'h1);
        @(posedge mclk);
        #1;
        chk(timer_count, 16'h0);
        rd(`TCM_OFS_STAT, rv);
        chk(rv, 16'h3);
        // match removed between trigger and reset edge
        adc_enable <= 1'b0;
        arm(`TCM_MODE_SPECIAL, 16'h2, 1'b1);
        wait_on(1);
        chk({trig, adc_start}, 16'h2);
        cv = timer_count;
        wr(`TCM_OFS_VLO, cv[7:0] + 8'h01);
        wait_on(2);
        chk(timer_clear, 16'h0);
        @(posedge mclk);
        #1;
        chk(timer_count, cv + 16'h1);
        chk(overflow_flag, 16'h0);
        report_and_stop();
    end

    initial
    begin
        #250000;
        fail_count++;
        report_and_stop();
    end
endmodule : timer_compare_match_unit_tb

`default_nettype wire
